/* File: inc/cmt_consts.vh */
// Register offsets, field positions and reset values of the CAN mask/timer register block
`ifndef CMT_CONSTS_VH
`define CMT_CONSTS_VH
// ----------------------------------------
// Register offsets (SFR addresses)
// ----------------------------------------
`define CMT_OFS_PRESCALE 8'ha1
`define CMT_OFS_MBOX_DATA 8'ha3
`define CMT_OFS_TTC_LOW 8'ha4
`define CMT_OFS_TTC_HIGH 8'ha5
`define CMT_OFS_MTIM_LOW 8'hac
`define CMT_OFS_MTIM_HIGH 8'had
`define CMT_OFS_STAMP_LOW 8'hae
`define CMT_OFS_STAMP_HIGH 8'haf
`define CMT_OFS_MASK2 8'hc5
`define CMT_OFS_MASK3 8'hc6
`define CMT_OFS_MASK4 8'hc7
// ----------------------------------------
// Field positions of the last mask byte
// ----------------------------------------
`define CMT_M4_ID_HI 7
`define CMT_M4_ID_LO 3
`define CMT_M4_RTR 2
`define CMT_M4_RSVD 1
`define CMT_M4_IDE 0
// ----------------------------------------
// Reset values
// ----------------------------------------
`define CMT_RST_PRESCALE 8'h00
`define CMT_RST_MTIM 16'h0000
`define CMT_RST_PTR 3'h0
`endif

/* File: rtl/cmt_mask_bit.v */
// One acceptance mask comparison slice
`timescale 1ns/1ps
module cmt_mask_bit #(
	parameter W = 1
) (
	input wire [W-1:0] mask,
	input wire [W-1:0] rx_bit,
	input wire [W-1:0] tag_bit,
	output wire [W-1:0] hit
);
	// Zero forces a match, one compares received against tag
	assign hit = ~mask | ~(rx_bit ^ tag_bit);
endmodule // cmt_mask_bit

/* File: rtl/cmt_regs.v */
// CAN mask, mailbox window and timer special function registers
`timescale 1ns/1ps
`include "cmt_consts.vh"
module cmt_regs #(
	parameter MBOX_BYTES = 8,
	parameter PTR_W = 3
) (
	input wire ref_clk,
	input wire rstn,
	input wire [7:0] sfr_addr,
	input wire sfr_wr,
	input wire sfr_rd,
	input wire [7:0] sfr_wdata,
	output reg [7:0] sfr_rdata,
	input wire auto_inc_en,
	input wire ptr_load,
	input wire [PTR_W-1:0] ptr_load_val,
	input wire [15:0] stamp_value,
	input wire stamp_capture,
	input wire [15:0] ttc_timer_value,
	input wire msg_timer_tick,
	input wire rx_filter_active,
	input wire [28:0] rx_id,
	input wire rx_rtr,
	input wire rx_ide,
	input wire [28:0] tag_id,
	input wire tag_rtr,
	input wire tag_ide,
	output reg rx_accept,
	output reg [7:0] timer_prescale_q,
	output reg prescale_tick_q,
	output reg [15:0] message_timer_value_q
);
	// ----------------------------------------
	// Storage
	// ----------------------------------------
	reg [7:0] mask2_q;
	reg [7:0] mask3_q;
	reg [7:0] mask4_q;
	reg [15:0] stamp_q;
	reg [7:0] mbox_mem [0:MBOX_BYTES-1];
	reg [PTR_W-1:0] mbox_ptr_q;
	reg [7:0] presc_cnt_q;
	wire [20:0] identifier_mask_bits;
	wire remote_request_mask_bit;
	wire extension_flag_mask_bit;
	wire [30:0] hit;
	wire mbox_acc;
	// id bits 20..13, 12..5, 4..0 across the three bytes
	assign identifier_mask_bits = {mask2_q, mask3_q, mask4_q[`CMT_M4_ID_HI:`CMT_M4_ID_LO]};
	assign remote_request_mask_bit = mask4_q[`CMT_M4_RTR];
	assign extension_flag_mask_bit = mask4_q[`CMT_M4_IDE];
	assign mbox_acc = (sfr_addr == `CMT_OFS_MBOX_DATA) && (sfr_wr || sfr_rd);
	// ----------------------------------------
	// Write decode
	// ----------------------------------------
	// Read-only and unmapped addresses decode to nothing, so writes there fall away
	wire wr_presc;
	wire wr_mtim_lo;
	wire wr_mtim_hi;
	wire wr_mask2;
	wire wr_mask3;
	wire wr_mask4;
	wire wr_mbox;
	wire filter_hit;
	assign wr_presc = sfr_wr && (sfr_addr == `CMT_OFS_PRESCALE);
	assign wr_mtim_lo = sfr_wr && (sfr_addr == `CMT_OFS_MTIM_LOW);
	assign wr_mtim_hi = sfr_wr && (sfr_addr == `CMT_OFS_MTIM_HIGH);
	assign wr_mask2 = sfr_wr && (sfr_addr == `CMT_OFS_MASK2);
	assign wr_mask3 = sfr_wr && (sfr_addr == `CMT_OFS_MASK3);
	assign wr_mask4 = sfr_wr && (sfr_addr == `CMT_OFS_MASK4);
	assign wr_mbox = sfr_wr && (sfr_addr == `CMT_OFS_MBOX_DATA);
	assign filter_hit = &hit;
	// ----------------------------------------
	// Acceptance comparison
	// ----------------------------------------
	// Upper id bits 28..21 are masked by a byte outside this block; compared always here
	cmt_mask_bit #(.W(31)) u_cmp (
		.mask({8'hff, identifier_mask_bits, remote_request_mask_bit, extension_flag_mask_bit}),
		.rx_bit({rx_id, rx_rtr, rx_ide}),
		.tag_bit({tag_id, tag_rtr, tag_ide}),
		.hit(hit)
	);
	// Filter result only qualified on reception; transmit path never sees it
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rx_accept <= 1'b0;
		end else begin
			rx_accept <= rx_filter_active & filter_hit;
		end
	end
	// ----------------------------------------
	// Unreset storage: mask, stamp, mailbox
	// ----------------------------------------
	// No reset on purpose: contents undefined until written
	always @(posedge ref_clk) begin
		if (wr_mask2) begin
			mask2_q <= sfr_wdata;
		end
		if (wr_mask3) begin
			mask3_q <= sfr_wdata;
		end
		if (wr_mask4) begin
			mask4_q <= sfr_wdata;
		end
		// Stamp follows its source only on a capture pulse
		if (stamp_capture) begin
			stamp_q <= stamp_value;
		end
		if (wr_mbox) begin
			mbox_mem[mbox_ptr_q] <= sfr_wdata;
		end
	end
	// ----------------------------------------
	// Mailbox pointer
	// ----------------------------------------
	// Pointer width sets the loop length, so wrap is natural overflow
	reg [PTR_W-1:0] mbox_ptr_d;
	// A page load wins over the step of an access in the same cycle
	always @* begin
		mbox_ptr_d = mbox_ptr_q;
		if (ptr_load) begin
			mbox_ptr_d = ptr_load_val;
		end else if (mbox_acc && auto_inc_en) begin
			mbox_ptr_d = mbox_ptr_q + {{(PTR_W-1){1'b0}}, 1'b1};
		end
	end
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			mbox_ptr_q <= `CMT_RST_PTR;
		end else begin
			mbox_ptr_q <= mbox_ptr_d;
		end
	end
	// ----------------------------------------
	// Prescaler and message timer
	// ----------------------------------------
	reg [7:0] presc_cnt_d;
	reg prescale_tick_d;
	reg [15:0] message_timer_value_d;
	// Divide base tick by prescale + 1; a count already at or past a lowered prescale ends on the next base tick
	always @* begin
		presc_cnt_d = presc_cnt_q;
		prescale_tick_d = 1'b0;
		if (msg_timer_tick) begin
			if (presc_cnt_q >= timer_prescale_q) begin
				presc_cnt_d = 8'h00;
				prescale_tick_d = 1'b1;
			end else begin
				presc_cnt_d = presc_cnt_q + 8'h01;
			end
		end
	end
	// Software write wins over a count in the same cycle; there is no byte latch,
	// so software reading a running timer must allow for a carry between bytes
	always @* begin
		message_timer_value_d = message_timer_value_q;
		if (wr_mtim_lo) begin
			message_timer_value_d[7:0] = sfr_wdata;
		end else if (wr_mtim_hi) begin
			message_timer_value_d[15:8] = sfr_wdata;
		end else if (prescale_tick_q) begin
			message_timer_value_d = message_timer_value_q + 16'h0001;
		end
	end
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			timer_prescale_q <= `CMT_RST_PRESCALE;
			presc_cnt_q <= 8'h00;
			prescale_tick_q <= 1'b0;
			message_timer_value_q <= `CMT_RST_MTIM;
		end else begin
			if (wr_presc) begin
				timer_prescale_q <= sfr_wdata;
			end
			presc_cnt_q <= presc_cnt_d;
			prescale_tick_q <= prescale_tick_d;
			message_timer_value_q <= message_timer_value_d;
		end
	end
	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	reg [7:0] rdata_d;
	always @* begin
		rdata_d = 8'h00;
		case (sfr_addr)
			`CMT_OFS_PRESCALE: rdata_d = timer_prescale_q;
			`CMT_OFS_MBOX_DATA: rdata_d = mbox_mem[mbox_ptr_q];
			`CMT_OFS_TTC_LOW: rdata_d = ttc_timer_value[7:0];
			`CMT_OFS_TTC_HIGH: rdata_d = ttc_timer_value[15:8];
			`CMT_OFS_MTIM_LOW: rdata_d = message_timer_value_q[7:0];
			`CMT_OFS_MTIM_HIGH: rdata_d = message_timer_value_q[15:8];
			`CMT_OFS_STAMP_LOW: rdata_d = stamp_q[7:0];
			`CMT_OFS_STAMP_HIGH: rdata_d = stamp_q[15:8];
			`CMT_OFS_MASK2: rdata_d = mask2_q;
			`CMT_OFS_MASK3: rdata_d = mask3_q;
			// Reserved bit reads back whatever was stored: undefined to software
			`CMT_OFS_MASK4: rdata_d = mask4_q;
			default: rdata_d = 8'h00;
		endcase
	end
	// Data holds until the next read, so a late sampler still sees it
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sfr_rdata <= 8'h00;
		end else if (sfr_rd) begin
			sfr_rdata <= rdata_d;
		end
	end
endmodule // cmt_regs

/* File: tb/cmt_regs_checker.sv */
// Port assertions for the CAN mask and timer register block
`timescale 1ns/1ps
module cmt_regs_checker (
	input wire ref_clk,
	input wire rstn,
	input wire [7:0] sfr_addr,
	input wire sfr_wr,
	input wire sfr_rd,
	input wire [7:0] sfr_wdata,
	input wire [7:0] sfr_rdata,
	input wire [15:0] ttc_timer_value,
	input wire rx_filter_active,
	input wire [28:0] rx_id,
	input wire rx_rtr,
	input wire rx_ide,
	input wire [28:0] tag_id,
	input wire tag_rtr,
	input wire tag_ide,
	input wire rx_accept,
	input wire [7:0] timer_prescale_q,
	input wire prescale_tick_q,
	input wire [15:0] message_timer_value_q
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	a_prescale_wr: assert property (sfr_wr && sfr_addr == 8'ha1 |=>
		timer_prescale_q == $past(sfr_wdata)) else $error("prescale write lost");
	a_prescale_rd: assert property (sfr_rd && sfr_addr == 8'ha1 |=>
		sfr_rdata == $past(timer_prescale_q)) else $error("prescale read wrong");
	a_ttc_high_rd: assert property (sfr_rd && sfr_addr == 8'ha5 |=>
		sfr_rdata == $past(ttc_timer_value[15:8])) else $error("ttc high read wrong");
	a_ttc_low_rd: assert property (sfr_rd && sfr_addr == 8'ha4 |=>
		sfr_rdata == $past(ttc_timer_value[7:0])) else $error("ttc low read wrong");
	a_mtim_low_wr: assert property (sfr_wr && sfr_addr == 8'hac |=>
		message_timer_value_q[7:0] == $past(sfr_wdata)) else $error("timer low write lost");
	a_mtim_high_wr: assert property (sfr_wr && sfr_addr == 8'had |=>
		message_timer_value_q[15:8] == $past(sfr_wdata)) else $error("timer high write lost");
	a_no_tx_filter: assert property (!rx_filter_active |=> !rx_accept)
		else $error("accept outside receive");
	a_equal_accept: assert property (rx_filter_active && rx_id == tag_id && rx_rtr == tag_rtr
		&& rx_ide == tag_ide |=> rx_accept) else $error("equal frame refused");
	a_timer_count: assert property (prescale_tick_q && !sfr_wr |=>
		message_timer_value_q == $past(message_timer_value_q) + 16'h0001)
		else $error("timer missed a tick");
	a_timer_hold: assert property (!prescale_tick_q && !sfr_wr |=>
		$stable(message_timer_value_q)) else $error("timer moved without a tick");
endmodule // cmt_regs_checker
bind cmt_regs cmt_regs_checker cmt_regs_checker_inst (.*);

/* File: tb/cmt_regs_tb_top.sv */
// Self-checking bench for the CAN mask and timer register block
`timescale 1ns/1ps
module cmt_regs_tb_top;
	logic ref_clk = 0, rstn = 0, sfr_wr = 0, sfr_rd = 0, auto_inc_en = 1, ptr_load = 0;
	logic stamp_capture = 0, msg_timer_tick = 0, rx_filter_active = 0, rx_rtr = 0, rx_ide = 1;
	logic tag_rtr = 0, tag_ide = 1, rx_accept, prescale_tick_q;
	logic [7:0] sfr_addr = 0, sfr_wdata = 0, sfr_rdata, timer_prescale_q, v;
	logic [2:0] ptr_load_val = 0;
	logic [15:0] stamp_value = 16'h1234, ttc_timer_value = 16'hbeef, message_timer_value_q;
	logic [28:0] rx_id = 0, tag_id = 0;
	// Rows: address, write data, expected read back
	logic [23:0] rows [11] = '{24'ha10505, 24'hac3434, 24'had1212, 24'hc5a5a5, 24'hc65a5a,
		24'hc7f9f9, 24'ha400ef, 24'ha500be, 24'haeff34, 24'hafff12, 24'h007700};
	int err_total = 0, checked = 0;
	cmt_regs cmt_regs_inst (.*);
	always #12.5 ref_clk = ~ref_clk;
	task chk(input string n, input logic [7:0] s, e);
		checked++;
		if (s !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task wr(input logic [7:0] a, d);
		@(posedge ref_clk);
		sfr_wr <= 1;
		sfr_addr <= a;
		sfr_wdata <= d;
		@(posedge ref_clk);
		sfr_wr <= 0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge ref_clk);
		sfr_rd <= 1;
		sfr_addr <= a;
		@(posedge ref_clk);
		sfr_rd <= 0;
		#1 v = sfr_rdata;
	endtask
	task pulse_ptr;
		@(posedge ref_clk);
		ptr_load <= 1;
		@(posedge ref_clk);
		ptr_load <= 0;
	endtask
	// Accept is registered, so look one edge after the frame fields land
	task flt(input logic act, input logic [28:0] id, input logic rtr, e);
		@(posedge ref_clk);
		rx_filter_active <= act;
		rx_id <= id;
		rx_rtr <= rtr;
		@(posedge ref_clk);
		#1 chk("accept", {7'h00, rx_accept}, {7'h00, e});
	endtask
	task print_verdict;
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		#100000;
		err_total++;
		print_verdict;
	end
	initial begin
		repeat (4) @(posedge ref_clk);
		rstn <= 1;
		@(posedge ref_clk);
		stamp_capture <= 1;
		@(posedge ref_clk);
		stamp_capture <= 0;
		foreach (rows[i]) begin
			wr(rows[i][23:16], rows[i][15:8]);
			rd(rows[i][23:16]);
			chk("register", v, rows[i][7:0]);
		end
		// Nine writes into eight slots: the last one must land on slot zero
		pulse_ptr;
		for (int i = 0; i < 9; i++)
			wr(8'ha3, 8'h40 + 8'(i));
		pulse_ptr;
		for (int i = 0; i < 8; i++) begin
			rd(8'ha3);
			chk("mailbox", v, (i == 0) ? 8'h48 : 8'h40 + 8'(i));
		end
		// Pointer stays put without auto-increment, and a page load lands
		auto_inc_en <= 0;
		ptr_load_val <= 3'h3;
		pulse_ptr;
		rd(8'ha3);
		chk("mailbox hold", v, 8'h43);
		rd(8'ha3);
		chk("mailbox hold", v, 8'h43);
		auto_inc_en <= 1;
		wr(8'hc5, 8'h00);
		wr(8'hc6, 8'h00);
		wr(8'hc7, 8'h00);
		flt(1, 29'h001fffff, 1, 1);
		wr(8'hc7, 8'h04);
		flt(1, 29'h0, 1, 0);
		flt(1, 29'h0, 0, 1);
		flt(0, 29'h0, 0, 0);
		rx_ide <= 0;
		flt(1, 29'h0, 0, 1);
		wr(8'hc7, 8'h01);
		flt(1, 29'h0, 0, 0);
		rx_ide <= 1;
		wr(8'hc7, 8'h08);
		flt(1, 29'h00000001, 0, 0);
		flt(1, 29'h00000002, 0, 1);
		wr(8'hc6, 8'h01);
		flt(1, 29'h00000020, 0, 0);
		flt(1, 29'h00000010, 0, 1);
		wr(8'hc5, 8'h01);
		flt(1, 29'h00002000, 0, 0);
		flt(1, 29'h00001000, 0, 1);
		flt(1, 29'h00200000, 0, 0);
		@(posedge ref_clk);
		rstn <= 0;
		@(posedge ref_clk);
		rstn <= 1;
		rd(8'ha1);
		chk("prescale", v, 8'h00);
		rd(8'hac);
		chk("timer low", v, 8'h00);
		rd(8'had);
		chk("timer high", v, 8'h00);
		// Prescale 2: the third base tick gives one pulse, then one count
		wr(8'ha1, 8'h02);
		@(posedge ref_clk);
		msg_timer_tick <= 1;
		repeat (2) @(posedge ref_clk);
		#1 chk("tick early", {7'h00, prescale_tick_q}, 8'h00);
		@(posedge ref_clk);
		msg_timer_tick <= 0;
		#1 chk("tick", {7'h00, prescale_tick_q}, 8'h01);
		rd(8'hac);
		chk("timer count", v, 8'h01);
		rd(8'had);
		chk("timer count high", v, 8'h00);
		print_verdict;
	end
endmodule // cmt_regs_tb_top
